// ===== msc_stats.sv
// Statistics counters with indirect read access
`timescale 1ns/10ps
`include "msc_defs.svh"
module msc_stats
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_ctrl_wr,
  input  wire logic [15:0] i_ctrl_data,
  input  wire logic        i_rx_done,
  input  wire logic [10:0] i_rx_len,
  input  wire logic        i_tx_done,
  input  wire logic        i_tx_good,
  input  wire logic        i_tx_pause,
  input  wire logic        i_tx_bcast,
  input  wire logic        i_tx_mcast,
  input  wire logic        i_tx_lowprio,
  input  wire logic [10:0] i_tx_len,
  input  wire logic        i_tx_deferred,
  input  wire logic [3:0]  i_tx_col_cnt,
  input  wire logic        i_tx_excess_col,
  input  wire logic        i_col_det,
  input  wire logic [9:0]  i_col_bit_time,
  input  wire logic        i_half_duplex,
  output logic [15:0]      o_data_upper,
  output logic [15:0]      o_data_lower
);
  logic [31:0]          inc;
  logic [10:0]          octets;
  logic [29:0]          cnt   [0:31];
  logic [31:0]          ovf;
  logic [31:0]          clr;
  logic [4:0]           idx_r;
  logic [4:0]           idx_nxt;
  msc_pkg::msc_state_t  st_r;
  msc_pkg::msc_state_t  st_nxt;
  logic [1:0]           wait_r;
  logic [1:0]           wait_nxt;
  logic [15:0]          up_nxt;
  logic [15:0]          lo_nxt;
  logic                 trig;

  // ************************************************************
  // Event decode and counter array
  // ************************************************************
  msc_event_decode i_msc_event_decode
  (
    .i_clk           (i_clk),
    .i_sys_rst       (i_sys_rst),
    .i_rx_done       (i_rx_done),
    .i_rx_len        (i_rx_len),
    .i_tx_done       (i_tx_done),
    .i_tx_good       (i_tx_good),
    .i_tx_pause      (i_tx_pause),
    .i_tx_bcast      (i_tx_bcast),
    .i_tx_mcast      (i_tx_mcast),
    .i_tx_lowprio    (i_tx_lowprio),
    .i_tx_len        (i_tx_len),
    .i_tx_deferred   (i_tx_deferred),
    .i_tx_col_cnt    (i_tx_col_cnt),
    .i_tx_excess_col (i_tx_excess_col),
    .i_col_det       (i_col_det),
    .i_col_bit_time  (i_col_bit_time),
    .i_half_duplex   (i_half_duplex),
    .o_inc           (inc),
    .o_octets        (octets)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `MSC_NUM_CNT; gi++)
    begin : g_cnt
      logic [10:0] amt;
      assign amt = (gi == `MSC_IDX_TX_OCTET) ? octets : 11'h1;
      msc_counter i_msc_counter
      (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_inc     (inc[gi]),
        .i_amount  (amt),
        .i_clear   (clr[gi]),
        .o_count   (cnt[gi]),
        .o_ovf     (ovf[gi])
      );
    end
  endgenerate

  // ************************************************************
  // Indirect read sequencer
  // ************************************************************
  assign trig = i_ctrl_wr &&
    ((i_ctrl_data & ~`MSC_CTRL_IDX_MASK) == `MSC_CTRL_READ_SEL);

  always_comb
  begin
    st_nxt   = st_r;
    idx_nxt  = idx_r;
    wait_nxt = wait_r;
    up_nxt   = o_data_upper;
    lo_nxt   = o_data_lower;
    clr      = 32'h0;
    if (trig)
    begin
      idx_nxt  = i_ctrl_data[4:0];
      wait_nxt = `MSC_READ_LAT;
      st_nxt   = msc_pkg::MSC_FETCH;
      up_nxt   = 16'h0;
      lo_nxt   = 16'h0;
    end
    else
    begin
      case (st_r)
        msc_pkg::MSC_IDLE:
        begin
          st_nxt = msc_pkg::MSC_IDLE;
        end
        msc_pkg::MSC_FETCH:
        begin
          if (wait_r != 2'h0)
          begin
            wait_nxt = wait_r - 2'h1;
          end
          else
          begin
            // Snapshot and clear in one cycle so no event is lost
            clr[idx_r] = (idx_r != `MSC_IDX_RESERVED);
            if (idx_r == `MSC_IDX_RESERVED)
            begin
              up_nxt = 16'h4000;
              lo_nxt = 16'h0;
            end
            else
            begin
              up_nxt = {ovf[idx_r], 1'b1, cnt[idx_r][29:16]};
              lo_nxt = cnt[idx_r][15:0];
            end
            st_nxt = msc_pkg::MSC_SHOW;
          end
        end
        msc_pkg::MSC_SHOW:
        begin
          st_nxt = msc_pkg::MSC_SHOW;
        end
        default:
        begin
          st_nxt = msc_pkg::MSC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      st_r         <= msc_pkg::MSC_IDLE;
      idx_r        <= 5'h0;
      wait_r       <= 2'h0;
      o_data_upper <= 16'h0;
      o_data_lower <= 16'h0;
    end
    else
    begin
      st_r         <= st_nxt;
      idx_r        <= idx_nxt;
      wait_r       <= wait_nxt;
      o_data_upper <= up_nxt;
      o_data_lower <= lo_nxt;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_trig;
    trig && !i_sys_rst;
  endsequence
  sequence s_fetch_quiet;
    !trig [*3];
  endsequence
  property p_valid_after_trig;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_trig |=> !o_data_upper[14] [*3];
  endproperty
  a_valid_after_trig: assert property (p_valid_after_trig)
    else $error("valid flag set too early");
  property p_valid_on_time;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_trig ##1 s_fetch_quiet |=> o_data_upper[14];
  endproperty
  a_valid_on_time: assert property (p_valid_on_time)
    else $error("valid flag not set after fetch");
  property p_reserved_zero;
    @(posedge i_clk) disable iff (i_sys_rst)
      (st_r == msc_pkg::MSC_SHOW && idx_r == `MSC_IDX_RESERVED) |->
        (o_data_upper[13:0] == 14'h0 && o_data_lower == 16'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved slot not zero");
  property p_clear_on_read;
    @(posedge i_clk) disable iff (i_sys_rst)
      (clr[`MSC_IDX_TX_PAUSE] && !inc[`MSC_IDX_TX_PAUSE]) |=>
        cnt[`MSC_IDX_TX_PAUSE] == 30'h0;
  endproperty
  a_clear_on_read: assert property (p_clear_on_read)
    else $error("counter not cleared on read");
  property p_full_duplex_quiet;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_col_det && !i_half_duplex) |=> !inc[`MSC_IDX_TX_ALLCOL];
  endproperty
  a_full_duplex_quiet: assert property (p_full_duplex_quiet)
    else $error("collision counted in full duplex");
  property p_pause_count;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_tx_done && i_tx_good && i_tx_pause) |=>
        inc[`MSC_IDX_TX_PAUSE] && !inc[`MSC_IDX_TX_UCAST];
  endproperty
  a_pause_count: assert property (p_pause_count)
    else $error("pause frame miscounted");
  property p_class_excl;
    @(posedge i_clk) disable iff (i_sys_rst)
      $onehot0(inc[`MSC_IDX_TX_UCAST:`MSC_IDX_TX_BCAST]);
  endproperty
  a_class_excl: assert property (p_class_excl)
    else $error("frame counted in two classes");
  property p_late_col;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_col_det && i_col_bit_time <= `MSC_LATE_BITS) |=>
        !inc[`MSC_IDX_TX_LATE];
  endproperty
  a_late_col: assert property (p_late_col)
    else $error("early collision counted late");
  property p_big_rx;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_rx_done && i_rx_len >= `MSC_RX_BIG_LEN) |=>
        inc[`MSC_IDX_RX_1024_UP];
  endproperty
  a_big_rx: assert property (p_big_rx)
    else $error("large packet not counted");
  property p_outputs_cleared;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_trig |=> (o_data_upper == 16'h0) && (o_data_lower == 16'h0);
  endproperty
  a_outputs_cleared: assert property (p_outputs_cleared)
    else $error("stale data after trigger");
  property p_data_stands;
    @(posedge i_clk) disable iff (i_sys_rst)
      (st_r == msc_pkg::MSC_SHOW && !trig) |=>
        $stable(o_data_upper) && $stable(o_data_lower);
  endproperty
  a_data_stands: assert property (p_data_stands)
    else $error("shown counter word changed");
  property p_reserved_quiet;
    @(posedge i_clk) disable iff (i_sys_rst)
      cnt[`MSC_IDX_RESERVED] == 30'h0;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet)
    else $error("reserved slot counted");
  property p_octet_sum;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_tx_done && i_tx_good && i_tx_lowprio) |=>
        inc[`MSC_IDX_TX_OCTET] && (octets == $past(i_tx_len));
  endproperty
  a_octet_sum: assert property (p_octet_sum)
    else $error("octets not added");
  property p_errored_excluded;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_tx_done && !i_tx_good) |=>
        (inc[`MSC_IDX_TX_UCAST:`MSC_IDX_TX_BCAST] == 3'h0) &&
        !inc[`MSC_IDX_TX_OCTET];
  endproperty
  a_errored_excluded: assert property (p_errored_excluded)
    else $error("errored frame counted");
  property p_deferral;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_tx_done && i_tx_deferred) |=> inc[`MSC_IDX_TX_DEFER];
  endproperty
  a_deferral: assert property (p_deferral)
    else $error("deferred frame not counted");
  property p_abort;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_tx_done && i_tx_excess_col) |=> inc[`MSC_IDX_TX_ABORT];
  endproperty
  a_abort: assert property (p_abort)
    else $error("abandoned frame not counted");
  property p_one_col;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_tx_done && i_tx_good && i_tx_col_cnt == 4'h1) |=>
        inc[`MSC_IDX_TX_ONECOL] && !inc[`MSC_IDX_TX_MULTCOL];
  endproperty
  a_one_col: assert property (p_one_col)
    else $error("single collision frame miscounted");
endmodule

// ===== msc_defs.svh
// Constants for the statistics counter block
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH
`define MSC_NUM_CNT        32
`define MSC_IDX_W          5
`define MSC_CNT_W          30
`define MSC_OVF_BIT        31
`define MSC_VALID_BIT      30
`define MSC_IDX_RX_1024_UP 5'h13
`define MSC_IDX_TX_OCTET   5'h14
`define MSC_IDX_RESERVED   5'h15
`define MSC_IDX_TX_LATE    5'h16
`define MSC_IDX_TX_PAUSE   5'h17
`define MSC_IDX_TX_BCAST   5'h18
`define MSC_IDX_TX_MCAST   5'h19
`define MSC_IDX_TX_UCAST   5'h1A
`define MSC_IDX_TX_DEFER   5'h1B
`define MSC_IDX_TX_ALLCOL  5'h1C
`define MSC_IDX_TX_ABORT   5'h1D
`define MSC_IDX_TX_ONECOL  5'h1E
`define MSC_IDX_TX_MULTCOL 5'h1F
`define MSC_CTRL_READ_SEL  16'h1C00
`define MSC_CTRL_IDX_MASK  16'h001F
`define MSC_RX_BIG_LEN     11'h400
`define MSC_LATE_BITS      10'h200
`define MSC_READ_LAT       2'h2
`endif

// ===== msc_pkg.sv
// Types for the statistics counter block
package msc_pkg;
  typedef enum logic [1:0]
  {
    MSC_IDLE  = 2'b00,
    MSC_FETCH = 2'b01,
    MSC_SHOW  = 2'b10
  } msc_state_t;
  typedef logic [31:0] msc_word_t;
endpackage

// ===== msc_event_decode.sv
// Turns MAC transmit and receive reports into per-counter increments
`timescale 1ns/10ps
`include "msc_defs.svh"
module msc_event_decode
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_rx_done,
  input  wire logic [10:0] i_rx_len,
  input  wire logic        i_tx_done,
  input  wire logic        i_tx_good,
  input  wire logic        i_tx_pause,
  input  wire logic        i_tx_bcast,
  input  wire logic        i_tx_mcast,
  input  wire logic        i_tx_lowprio,
  input  wire logic [10:0] i_tx_len,
  input  wire logic        i_tx_deferred,
  input  wire logic [3:0]  i_tx_col_cnt,
  input  wire logic        i_tx_excess_col,
  input  wire logic        i_col_det,
  input  wire logic [9:0]  i_col_bit_time,
  input  wire logic        i_half_duplex,
  output logic [31:0]      o_inc,
  output logic [10:0]      o_octets
);
  logic [31:0] inc_nxt;
  logic [10:0] oct_nxt;
  logic        good;
  always_comb
  begin
    inc_nxt = 32'h0;
    oct_nxt = 11'h0;
    good    = i_tx_done && i_tx_good;
    inc_nxt[`MSC_IDX_RX_1024_UP] = i_rx_done && (i_rx_len >= `MSC_RX_BIG_LEN);
    if (good && (i_tx_lowprio || i_tx_pause))
    begin
      inc_nxt[`MSC_IDX_TX_OCTET] = 1'b1;
      oct_nxt = i_tx_len;
    end
    inc_nxt[`MSC_IDX_TX_LATE] = i_col_det && (i_col_bit_time > `MSC_LATE_BITS);
    inc_nxt[`MSC_IDX_TX_PAUSE] = good && i_tx_pause;
    inc_nxt[`MSC_IDX_TX_BCAST] = good && !i_tx_pause && i_tx_bcast;
    inc_nxt[`MSC_IDX_TX_MCAST] = good && !i_tx_pause && !i_tx_bcast && i_tx_mcast;
    inc_nxt[`MSC_IDX_TX_UCAST] = good && !i_tx_pause && !i_tx_bcast && !i_tx_mcast;
    inc_nxt[`MSC_IDX_TX_DEFER] = i_tx_done && i_tx_deferred;
    inc_nxt[`MSC_IDX_TX_ALLCOL] = i_col_det && i_half_duplex;
    inc_nxt[`MSC_IDX_TX_ABORT] = i_tx_done && i_tx_excess_col;
    inc_nxt[`MSC_IDX_TX_ONECOL] = good && (i_tx_col_cnt == 4'h1);
    inc_nxt[`MSC_IDX_TX_MULTCOL] = good && (i_tx_col_cnt > 4'h1);
    inc_nxt[`MSC_IDX_RESERVED] = 1'b0;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_inc    <= 32'h0;
      o_octets <= 11'h0;
    end
    else
    begin
      o_inc    <= inc_nxt;
      o_octets <= oct_nxt;
    end
  end
endmodule

// ===== msc_counter.sv
// One counter word with wrap-to-overflow and read clear
`timescale 1ns/10ps
`include "msc_defs.svh"
module msc_counter
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_inc,
  input  wire logic [10:0] i_amount,
  input  wire logic        i_clear,
  output logic [29:0]      o_count,
  output logic             o_ovf
);
  logic [29:0] cnt_nxt;
  logic        ovf_nxt;
  logic [30:0] sum;
  always_comb
  begin
    sum     = {1'b0, o_count} + {20'h0, i_amount};
    cnt_nxt = o_count;
    ovf_nxt = o_ovf;
    if (i_clear)
    begin
      cnt_nxt = 30'h0;
      ovf_nxt = 1'b0;
    end
    if (i_inc)
    begin
      // Event during the clear starts the fresh count
      cnt_nxt = i_clear ? {19'h0, i_amount} : sum[29:0];
      ovf_nxt = (!i_clear && sum[30]) || ovf_nxt;
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_count <= 30'h0;
      o_ovf   <= 1'b0;
    end
    else
    begin
      o_count <= cnt_nxt;
      o_ovf   <= ovf_nxt;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_ovf_sticky;
    @(posedge i_clk) disable iff (i_sys_rst)
      (o_ovf && !i_clear) |=> o_ovf;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky)
    else $error("overflow flag dropped without read");
  property p_ovf_on_wrap;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_inc && !i_clear && (o_count > (30'h3FFFFFFF - {19'h0, i_amount})))
        |=> o_ovf;
  endproperty
  a_ovf_on_wrap: assert property (p_ovf_on_wrap)
    else $error("wrap did not set overflow");
  property p_read_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_clear && !i_inc) |=> (o_count == 30'h0) && !o_ovf;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("counter word not cleared");
endmodule

// ===== msc_host_model.sv
// Host software model that reads counters through the indirect registers
`timescale 1ns/10ps
module msc_host_model
(
  input  wire logic        i_clk,
  input  wire logic [15:0] i_data_upper,
  input  wire logic [15:0] i_data_lower,
  output logic             o_ctrl_wr,
  output logic [15:0]      o_ctrl_data
);
  // ********************
  // Indirect access
  // ********************
  initial
  begin
    o_ctrl_wr   = 1'b0;
    o_ctrl_data = 16'h0000;
  end

  // One-cycle write of the control register
  task automatic write_ctrl(input logic [15:0] d);
    @(posedge i_clk);
    #1;
    o_ctrl_wr   = 1'b1;
    o_ctrl_data = d;
    @(posedge i_clk);
    #1;
    o_ctrl_wr   = 1'b0;
    o_ctrl_data = ~d;
  endtask

  // Counters are read soon after traffic, long before they can wrap
  task automatic read_counter(input logic [4:0] idx, output logic [31:0] w);
    int n;
    write_ctrl({11'h0E0, idx});
    n = 0;
    while (n < 20 && i_data_upper[14] !== 1'b1)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    w[31:16] = i_data_upper;
    w[15:0]  = i_data_lower;
  endtask
endmodule

// ===== tb_msc_stats.sv
// Testbench for the statistics counter block
`timescale 1ns/10ps
module tb_msc_stats;
  logic        clk;
  logic        sys_rst;
  logic        ctrl_wr;
  logic [15:0] ctrl_data;
  logic        rx_done;
  logic [10:0] rx_len;
  logic        tx_done;
  logic        tx_good;
  logic        tx_pause;
  logic        tx_bcast;
  logic        tx_mcast;
  logic        tx_lowprio;
  logic [10:0] tx_len;
  logic        tx_deferred;
  logic [3:0]  tx_col_cnt;
  logic        tx_excess_col;
  logic        col_det;
  logic [9:0]  col_bit_time;
  logic        half_duplex;
  logic [15:0] data_upper;
  logic [15:0] data_lower;
  int          miscompares;
  int          n_compared;

  msc_stats i_msc_stats
  (
    .i_clk(clk), .i_sys_rst(sys_rst), .i_ctrl_wr(ctrl_wr),
    .i_ctrl_data(ctrl_data), .i_rx_done(rx_done), .i_rx_len(rx_len),
    .i_tx_done(tx_done), .i_tx_good(tx_good), .i_tx_pause(tx_pause),
    .i_tx_bcast(tx_bcast), .i_tx_mcast(tx_mcast),
    .i_tx_lowprio(tx_lowprio), .i_tx_len(tx_len),
    .i_tx_deferred(tx_deferred), .i_tx_col_cnt(tx_col_cnt),
    .i_tx_excess_col(tx_excess_col), .i_col_det(col_det),
    .i_col_bit_time(col_bit_time), .i_half_duplex(half_duplex),
    .o_data_upper(data_upper), .o_data_lower(data_lower)
  );

  msc_host_model i_msc_host_model
  (
    .i_clk(clk), .i_data_upper(data_upper), .i_data_lower(data_lower),
    .o_ctrl_wr(ctrl_wr), .o_ctrl_data(ctrl_data)
  );

  // ********************
  // Helpers
  // ********************
  always #10 clk = ~clk;

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic expect_cnt(input logic [4:0] idx, input logic [29:0] n);
    logic [31:0] w;
    i_msc_host_model.read_counter(idx, w);
    check($sformatf("counter %h", idx), w, {2'b01, n});
  endtask

  // Flags: good, pause, bcast, mcast, lowprio, deferred, excess
  task automatic tx(input logic [6:0] f, input logic [10:0] len,
                    input logic [3:0] cc);
    @(posedge clk);
    #1;
    tx_done = 1'b1;
    {tx_good, tx_pause, tx_bcast, tx_mcast} = f[6:3];
    {tx_lowprio, tx_deferred, tx_excess_col} = f[2:0];
    tx_len = len;
    tx_col_cnt = cc;
    @(posedge clk);
    #1;
    tx_done = 1'b0;
  endtask

  task automatic rx(input logic [10:0] len);
    @(posedge clk);
    #1;
    rx_done = 1'b1;
    rx_len = len;
    @(posedge clk);
    #1;
    rx_done = 1'b0;
  endtask

  task automatic col(input logic [9:0] bt);
    @(posedge clk);
    #1;
    col_det = 1'b1;
    col_bit_time = bt;
    @(posedge clk);
    #1;
    col_det = 1'b0;
  endtask

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ********************
  // Tests
  // ********************
  initial
  begin
    #400000;
    miscompares++;
    print_verdict();
  end

  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {rx_done, tx_done, col_det, half_duplex} = 4'h0;
    {tx_good, tx_pause, tx_bcast, tx_mcast} = 4'h0;
    {tx_lowprio, tx_deferred, tx_excess_col} = 3'h0;
    {rx_len, tx_len, tx_col_cnt, col_bit_time} = 36'h0;
    miscompares = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 32; i++)
      expect_cnt(i[4:0], 30'h0);
    $display("test reset_values done");
    rx(11'h3FF);
    rx(11'h400);
    rx(11'h5F2);
    expect_cnt(5'h13, 30'h2);
    $display("test rx_length done");
    tx(7'b1010100, 11'h064, 4'h0);
    tx(7'b1001100, 11'h040, 4'h0);
    tx(7'b1000000, 11'h0C8, 4'h0);
    tx(7'b1101000, 11'h040, 4'h0);
    tx(7'b0010100, 11'h050, 4'h0);
    expect_cnt(5'h14, 30'hE4);
    expect_cnt(5'h17, 30'h1);
    expect_cnt(5'h18, 30'h1);
    expect_cnt(5'h19, 30'h1);
    expect_cnt(5'h1A, 30'h1);
    expect_cnt(5'h15, 30'h0);
    expect_cnt(5'h18, 30'h0);
    $display("test tx_classes done");
    half_duplex = 1'b1;
    col(10'h200);
    col(10'h201);
    half_duplex = 1'b0;
    col(10'h064);
    expect_cnt(5'h1C, 30'h2);
    expect_cnt(5'h16, 30'h1);
    tx(7'b1000010, 11'h064, 4'h0);
    tx(7'b1000000, 11'h064, 4'h1);
    tx(7'b1000000, 11'h064, 4'h2);
    tx(7'b0000001, 11'h064, 4'hF);
    expect_cnt(5'h1B, 30'h1);
    expect_cnt(5'h1E, 30'h1);
    expect_cnt(5'h1F, 30'h1);
    expect_cnt(5'h1D, 30'h1);
    $display("test collisions done");
    tx(7'b1010000, 11'h064, 4'h0);
    i_msc_host_model.write_ctrl(16'h1C18);
    expect_cnt(5'h17, 30'h0);
    expect_cnt(5'h18, 30'h1);
    i_msc_host_model.write_ctrl(16'h0018);
    repeat (5) @(posedge clk);
    check("ignored write", {data_upper, data_lower}, 32'h40000001);
    $display("test restart done");
    print_verdict();
  end
endmodule
